// ===== design/uhf_defines.svh
// Register offsets, field positions, reset values and timing counts
`ifndef UHF_DEFINES_SVH
`define UHF_DEFINES_SVH
`define UHF_OFF_FLAGS      4'h0
`define UHF_OFF_MASK       4'h4
`define UHF_OFF_ERRFLAGS   4'h8
`define UHF_OFF_ERRENABLE  4'hC
`define UHF_OFF_STATUS     5'h10
`define UHF_BIT_STALL      7
`define UHF_BIT_ATTACH     6
`define UHF_BIT_RESUME     5
`define UHF_BIT_IDLE       4
`define UHF_BIT_TOKEN      3
`define UHF_BIT_FRAME      2
`define UHF_BIT_ERROR      1
`define UHF_BIT_DETACH     0
`define UHF_RST_FLAGS      8'h00
`define UHF_RST_MASK       8'h00
`define UHF_CLK_MHZ        100
`define UHF_ATTACH_NS      2500
`define UHF_RESUME_NS      2500
`define UHF_IDLE_US        3000
`define UHF_ATTACH_CYC     ((`UHF_ATTACH_NS * `UHF_CLK_MHZ + 999) / 1000)
`define UHF_RESUME_CYC     ((`UHF_RESUME_NS * `UHF_CLK_MHZ + 999) / 1000)
`define UHF_IDLE_CYC       (`UHF_IDLE_US * `UHF_CLK_MHZ)
`endif

// ===== design/uhf_evt_if.sv
// Interface carrying bus-condition events between the detector and the top
`timescale 1ns/10ps
interface uhf_evt_if;
   logic attach;
   logic resume;
   logic idle;
   modport det (output attach, output resume, output idle);
   modport top (input attach, input resume, input idle);
endinterface : uhf_evt_if

// ===== design/uhf_irq_flags.sv
// Host-mode interrupt flag register with Wishbone slave and status FIFO
//
// Functional notes
// RULE1: Upper byte of the flag register is unimplemented and reads zero.
// RULE2: Stall flag sets when a STALL handshake was sent.
// RULE3: Attach flag sets after non-SE0 and no activity for 2.5 us.
// RULE4: Resume flag sets after K-state persists 2.5 us.
// RULE5: Idle flag sets after 3 ms of continuous idle.
// RULE6: Token flag sets at token end; its status is then readable.
// RULE7: Frame flag sets at host threshold or received frame token.
// RULE8: Error summary is read-only, set only by enabled error flags.
// RULE9: Detach flag sets on detach, not again until reset state clears.
// RULE10: Flags clear only by word write with a one in that bit.
// RULE11: Software must not use bitwise or read-modify-write to clear.
// RULE12: Clearing the token flag advances the token status FIFO.
// RULE13: A hardware set in the clearing cycle wins over the clear.
//
// Our own choices: register access over Wishbone and the register addresses.
`include "uhf_defines.svh"
`timescale 1ns/10ps
module uhf_irq_flags #(
   parameter int ATTACH_CYC = `UHF_ATTACH_CYC,
   parameter int RESUME_CYC = `UHF_RESUME_CYC,
   parameter int IDLE_CYC   = `UHF_IDLE_CYC,
   parameter int STAT_DEPTH = 4
) (
   // Clock, reset, enable
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        CE,
   // Wishbone slave
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [4:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output logic      [31:0] WB_DAT_O,
   output logic             WB_ACK_O,
   // USB line pins (asynchronous)
   input  wire logic        DP_IN,
   input  wire logic        DM_IN,
   // Protocol engine events (same clock)
   input  wire logic        LOW_SPEED,
   input  wire logic        BUS_ACTIVITY,
   input  wire logic        STALL_SENT,
   input  wire logic        TOKEN_DONE,
   input  wire logic [7:0]  TOKEN_STATUS,
   input  wire logic        FRAME_EVENT,
   input  wire logic        DETACH_SEEN,
   input  wire logic        RESET_STATE,
   input  wire logic [7:0]  ERROR_EVENTS,
   // Interrupt
   output logic             IRQ
);
   localparam int PW = $clog2(STAT_DEPTH);
   // Refuse depths the wrapping pointers cannot serve
   if (STAT_DEPTH < 2 || (STAT_DEPTH & (STAT_DEPTH - 1)) != 0) begin : g_bad
      $error("uhf_irq_flags: STAT_DEPTH must be a power of two >= 2");
   end

   ////////////////////////////////////////////////////////////////////////
   // Pin synchroniser and line-state detection
   logic [1:0] pin_s1_q;
   logic [1:0] pin_s2_q;
   // Two stages: the first is read by the second only
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pin_s1_q <= 2'h0;
         pin_s2_q <= 2'h0;
      end else if (CE) begin
         pin_s1_q <= {DP_IN, DM_IN};
         pin_s2_q <= pin_s1_q;
      end
   end
   uhf_pkg::uhf_line_t line_w;
   assign line_w = (pin_s2_q == 2'h0) ? uhf_pkg::UHF_SE0 :
                   (pin_s2_q == 2'h2) ? uhf_pkg::UHF_J   :
                   (pin_s2_q == 2'h1) ? uhf_pkg::UHF_K   : uhf_pkg::UHF_SE1;

   uhf_evt_if evt ();
   uhf_line_det #(
      .ATTACH_CYC (ATTACH_CYC),
      .RESUME_CYC (RESUME_CYC),
      .IDLE_CYC   (IDLE_CYC)
   ) u_det (
      .clk       (CLK),
      .rst       (RST),
      .ce        (CE),
      .line      (line_w),
      .activity  (BUS_ACTIVITY),
      .low_speed (LOW_SPEED),
      .evt       (evt)
   );

   ////////////////////////////////////////////////////////////////////////
   // Bus decode
   function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
      hit = (a == o);
   endfunction : hit

   wire req      = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   wire wr       = req && WB_WE_I && CE;
   // Flags clear only on a full low-word write, not a byte update
   wire word_wr  = wr && (WB_SEL_I[1:0] == 2'h3);
   wire wr_flags = word_wr && hit(WB_ADR_I, 5'(`UHF_OFF_FLAGS));
   wire wr_mask  = wr && WB_SEL_I[0] && hit(WB_ADR_I, 5'(`UHF_OFF_MASK));
   wire wr_eflg  = word_wr && hit(WB_ADR_I, 5'(`UHF_OFF_ERRFLAGS));
   wire wr_een   = wr && WB_SEL_I[0] && hit(WB_ADR_I, 5'(`UHF_OFF_ERRENABLE));

   ////////////////////////////////////////////////////////////////////////
   // Error flags and their summary
   logic [7:0] err_q;
   logic [7:0] err_en_q;
   wire  [7:0] err_clr = wr_eflg ? WB_DAT_I[7:0] : 8'h00;
   // Hardware set wins over a simultaneous write-one clear
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         err_q    <= 8'h00;
         err_en_q <= 8'h00;
      end else if (CE) begin
         err_q <= (err_q & ~err_clr) | ERROR_EVENTS;      // see RULE13
         if (wr_een)
            err_en_q <= WB_DAT_I[7:0];
      end
   end
   wire err_sum = |(err_q & err_en_q);                   // see RULE8

   ////////////////////////////////////////////////////////////////////////
   // Token status FIFO
   logic [7:0]    stat_mem_q [STAT_DEPTH];
   logic [PW:0]   wp_q;
   logic [PW:0]   rp_q;
   wire           st_empty = (wp_q == rp_q);
   wire           st_full  = (wp_q[PW-1:0] == rp_q[PW-1:0]) &&
                             (wp_q[PW] != rp_q[PW]);
   wire           st_push  = CE && TOKEN_DONE && !st_full;
   logic [7:0]    flags_q;
   wire           tok_clr  = wr_flags && WB_DAT_I[`UHF_BIT_TOKEN] &&
                             flags_q[`UHF_BIT_TOKEN];
   wire           st_pop   = tok_clr && !st_empty;       // see RULE12
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         wp_q <= '0;
         rp_q <= '0;
      end else begin
         if (st_push)
            wp_q <= wp_q + 1'b1;
         if (st_pop)
            rp_q <= rp_q + 1'b1;
      end
   end
   // Storage has no reset; entries are only read once written
   always_ff @(posedge CLK) begin
      if (st_push)
         stat_mem_q[wp_q[PW-1:0]] <= TOKEN_STATUS;
   end
   wire [PW:0] rp_next   = st_pop ? rp_q + 1'b1 : rp_q;
   wire        more_left = st_pop && (rp_next != wp_q);

   ////////////////////////////////////////////////////////////////////////
   // Flag register
   logic detach_armed_q;
   logic [7:0] mask_q;
   wire  [7:0] clr_vec  = wr_flags ? WB_DAT_I[7:0] : 8'h00;
   wire  [7:0] set_vec;
   assign set_vec[`UHF_BIT_STALL]  = STALL_SENT;               // see RULE2
   assign set_vec[`UHF_BIT_ATTACH] = evt.attach;               // see RULE3
   assign set_vec[`UHF_BIT_RESUME] = evt.resume;               // see RULE4
   assign set_vec[`UHF_BIT_IDLE]   = evt.idle;                 // see RULE5
   assign set_vec[`UHF_BIT_TOKEN]  = st_push || more_left;     // see RULE6
   assign set_vec[`UHF_BIT_FRAME]  = FRAME_EVENT;              // see RULE7
   assign set_vec[`UHF_BIT_ERROR]  = 1'b0;
   assign set_vec[`UHF_BIT_DETACH] = DETACH_SEEN &&
                                     detach_armed_q;           // see RULE9
   wire  [7:0] flags_d  = (flags_q & ~clr_vec) | set_vec;     // see RULE10
   wire  [7:0] flags_rd = {flags_q[7:2], err_sum, flags_q[0]}; // see RULE8
   wire        hw_set   = CE && (DETACH_SEEN && detach_armed_q);

   // Flag bits; set outranks the write-one clear
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         flags_q        <= `UHF_RST_FLAGS;
         mask_q         <= `UHF_RST_MASK;
         detach_armed_q <= 1'b1;
      end else if (CE) begin
         flags_q <= flags_d;                                   // see RULE13
         if (wr_mask)
            mask_q <= WB_DAT_I[7:0];
         if (hw_set)
            detach_armed_q <= 1'b0;                            // see RULE9
         else if (!RESET_STATE && !flags_q[`UHF_BIT_DETACH])
            detach_armed_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read mux, acknowledge and interrupt
   wire [31:0] rd_w =
      hit(WB_ADR_I, 5'(`UHF_OFF_FLAGS))     ? {24'h0, flags_rd} :  // see RULE1
      hit(WB_ADR_I, 5'(`UHF_OFF_MASK))      ? {24'h0, mask_q}   :
      hit(WB_ADR_I, 5'(`UHF_OFF_ERRFLAGS))  ? {24'h0, err_q}    :
      hit(WB_ADR_I, 5'(`UHF_OFF_ERRENABLE)) ? {24'h0, err_en_q} :
      hit(WB_ADR_I, `UHF_OFF_STATUS)        ?
         {24'h0, st_empty ? 8'h00 : stat_mem_q[rp_q[PW-1:0]]}   : // see RULE6
      32'h0000_0000;
   // Single-wait-state acknowledge; unmapped reads return zero
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         WB_ACK_O <= 1'b0;
         WB_DAT_O <= 32'h0000_0000;
         IRQ      <= 1'b0;
      end else if (CE) begin
         WB_ACK_O <= req;
         WB_DAT_O <= req ? rd_w : 32'h0000_0000;
         IRQ      <= |(flags_rd & mask_q);   // Summary bit included
      end
   end
endmodule : uhf_irq_flags

// ===== design/uhf_line_det.sv
// Line-state detector: attach, resume and idle from the synchronised lines
`timescale 1ns/10ps
module uhf_line_det #(
   parameter int ATTACH_CYC = 250,
   parameter int RESUME_CYC = 250,
   parameter int IDLE_CYC   = 300000
) (
   input  wire logic            clk,
   input  wire logic            rst,
   input  wire logic            ce,
   input  uhf_pkg::uhf_line_t   line,
   input  wire logic            activity,
   input  wire logic            low_speed,
   uhf_evt_if.det               evt
);
   // K is differential one at low speed, differential zero at full speed
   wire is_k    = low_speed ? (line == uhf_pkg::UHF_J)
                            : (line == uhf_pkg::UHF_K);
   wire is_j    = low_speed ? (line == uhf_pkg::UHF_K)
                            : (line == uhf_pkg::UHF_J);
   wire not_se0 = (line != uhf_pkg::UHF_SE0) && !activity;
   uhf_timer #(.N(ATTACH_CYC)) u_att (.clk(clk), .rst(rst), .ce(ce),
      .cond(not_se0), .hit(evt.attach));                 // see RULE3
   uhf_timer #(.N(RESUME_CYC)) u_res (.clk(clk), .rst(rst), .ce(ce),
      .cond(is_k), .hit(evt.resume));                    // see RULE4
   uhf_timer #(.N(IDLE_CYC)) u_idl (.clk(clk), .rst(rst), .ce(ce),
      .cond(is_j && !activity), .hit(evt.idle));         // see RULE5
endmodule : uhf_line_det

// ===== design/uhf_pkg.sv
// Types shared by the interrupt flag block
package uhf_pkg;
   typedef enum logic [1:0] {
      UHF_SE0,
      UHF_J,
      UHF_K,
      UHF_SE1
   } uhf_line_t;
   typedef logic [7:0] uhf_byte_t;
endpackage : uhf_pkg

// ===== design/uhf_timer.sv
// Persistence timer: pulses once when a condition has held for N cycles
`timescale 1ns/10ps
module uhf_timer #(
   parameter int N = 250
) (
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic ce,
   input  wire logic cond,
   output logic      hit
);
   localparam int W = $clog2(N + 1);
   logic [W-1:0] cnt_q;
   // Refuse a count the terminal compare cannot reach
   if (N < 1) begin : g_bad_n
      $error("uhf_timer: N must be at least one");
   end
   // Counts while the condition holds; one pulse at the terminal count
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
         hit   <= 1'b0;
      end else if (ce) begin
         hit <= cond && (cnt_q == W'(N - 1));
         if (!cond)
            cnt_q <= '0;
         else if (cnt_q != W'(N))
            cnt_q <= cnt_q + 1'b1;
      end
   end
endmodule : uhf_timer

// ===== test/tb_top.sv
// Self-checking bench for the host interrupt flag block
`timescale 1ns/10ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin \
   mismatches++; $display("wrong value %s exp %h got %h", nm, e, a); end end
module tb_top;
   logic               clk = 1'b0, rst = 1'b1, ce = 1'b1, rst_st = 1'b0;
   logic               ls = 1'b0, act = 1'b0;
   logic               cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, irq, dp, dm;
   logic [3:0]         sel = 4'h0, ev = 4'h0;
   logic [4:0]         adr = 5'h00;
   logic [7:0]         tstat = 8'h00, errs = 8'h00;
   logic [31:0]        wdat = 32'h0, rdat, got;
   uhf_pkg::uhf_line_t line = uhf_pkg::UHF_SE0;
   int                 mismatches = 0, n_compared = 0;
   // Short counts keep the line timers within a brief run
   uhf_irq_flags #(.ATTACH_CYC(8), .RESUME_CYC(8), .IDLE_CYC(50)) dut (
      .CLK(clk), .RST(rst), .CE(ce), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
      .WB_DAT_O(rdat), .WB_ACK_O(ack), .DP_IN(dp), .DM_IN(dm),
      .LOW_SPEED(ls), .BUS_ACTIVITY(act), .STALL_SENT(ev[3]),
      .TOKEN_DONE(ev[2]), .TOKEN_STATUS(tstat), .FRAME_EVENT(ev[1]),
      .DETACH_SEEN(ev[0]), .RESET_STATE(rst_st), .ERROR_EVENTS(errs),
      .IRQ(irq));
   uhf_peer_model peer (.line(line), .low_speed(ls), .dp(dp), .dm(dm));
   // Clock
   always #5 clk = ~clk;
   // Verdict and end of run
   task automatic end_of_test;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : end_of_test
   // Classic cycle; idle edge at the end so calls never collide
   task automatic wb(input logic w, input logic [4:0] a,
                     input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      {cyc, stb, we, adr, sel, wdat} <= {2'b11, w, a, s, d};
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 64);
      got = rdat;
      {cyc, stb, we} <= 3'h0;
      @(posedge clk);
      if (n >= 64) begin
         mismatches++;
         end_of_test();
      end
   endtask : wb
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      wb(1'b1, a, d, 4'hF);
   endtask : wr
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0, 4'hF);
      `CHK($sformatf("reg %h", a), e, got)
   endtask : rd
   // One-cycle event pulses, levels held for one edge only
   task automatic pulse(input logic [3:0] v, input logic [7:0] e);
      @(posedge clk);
      {ev, errs} <= {v, e};
      @(posedge clk);
      {ev, errs} <= 12'h000;
   endtask : pulse
   task automatic t_reset;
      rd(5'h00, 32'h0);
      rd(5'h10, 32'h0);
      wr(5'h1C, 32'hFF);
      rd(5'h1C, 32'h0);
      // A frame pulse while enable is low must leave no trace
      ce <= 1'b0;
      pulse(4'h2, 8'h00);
      ce <= 1'b1;
      rd(5'h00, 32'h0);
      $display("test reset done");
   endtask : t_reset
   task automatic t_events;
      wr(5'h04, 32'hFF);
      pulse(4'hB, 8'h00);
      rd(5'h00, 32'h85);
      `CHK("irq", 1'b1, irq)
      wr(5'h00, 32'h04);
      wb(1'b1, 5'h00, 32'h81, 4'h1);
      rd(5'h00, 32'h81);
      rst_st <= 1'b1;
      wr(5'h00, 32'h81);
      pulse(4'h1, 8'h00);
      rd(5'h00, 32'h00);
      rst_st <= 1'b0;
      pulse(4'h1, 8'h00);
      rd(5'h00, 32'h01);
      // Stall lands on the very edge that takes the clear
      fork
         wr(5'h00, 32'h81);
         begin
            ev <= 4'h8;
            @(posedge clk);
            ev <= 4'h0;
         end
      join
      rd(5'h00, 32'h80);
      wr(5'h00, 32'hFF);
      `CHK("irq", 1'b0, irq)
      $display("test events done");
   endtask : t_events
   task automatic t_error;
      pulse(4'h0, 8'h01);
      rd(5'h00, 32'h00);
      wr(5'h0C, 32'h01);
      wr(5'h00, 32'h02);
      rd(5'h00, 32'h02);
      `CHK("irq", 1'b1, irq)
      wr(5'h08, 32'h01);
      rd(5'h00, 32'h00);
      $display("test error done");
   endtask : t_error
   task automatic t_token;
      tstat <= 8'hA1;
      pulse(4'h4, 8'h00);
      tstat <= 8'hB2;
      pulse(4'h4, 8'h00);
      rd(5'h10, 32'hA1);
      wr(5'h00, 32'h08);
      rd(5'h10, 32'hB2);
      rd(5'h00, 32'h08);
      wr(5'h00, 32'h08);
      rd(5'h10, 32'h00);
      $display("test token done");
   endtask : t_token
   task automatic t_lines;
      line <= uhf_pkg::UHF_J;
      repeat (3) @(posedge clk);
      rd(5'h00, 32'h00);
      repeat (70) @(posedge clk);
      rd(5'h00, 32'h50);
      wr(5'h00, 32'h50);
      line <= uhf_pkg::UHF_K;
      repeat (20) @(posedge clk);
      rd(5'h00, 32'h20);
      // Low speed puts K on D+; activity must hold off attach
      wr(5'h00, 32'h20);
      line <= uhf_pkg::UHF_SE0;
      repeat (4) @(posedge clk);
      {ls, act} <= 2'b11;
      line      <= uhf_pkg::UHF_K;
      repeat (20) @(posedge clk);
      rd(5'h00, 32'h20);
      {ls, act} <= 2'b00;
      line      <= uhf_pkg::UHF_SE0;
      $display("test lines done");
   endtask : t_lines
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_events();
      t_error();
      t_token();
      t_lines();
      end_of_test();
   end
endmodule : tb_top

// ===== test/uhf_irq_flags_sva.sv
// Bus and interrupt checks for the host interrupt flag block
`timescale 1ns/10ps
module uhf_irq_flags_sva (
   // Clock, reset, enable
   input wire logic        CLK,
   input wire logic        RST,
   input wire logic        CE,
   // Wishbone
   input wire logic        WB_CYC_I,
   input wire logic        WB_STB_I,
   input wire logic        WB_WE_I,
   input wire logic [31:0] WB_DAT_O,
   input wire logic        WB_ACK_O,
   // Interrupt
   input wire logic        IRQ
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O) // one cycle
      else $error("ack held longer than one cycle");
   ack_timing_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O && CE
      |=> WB_ACK_O) else $error("request not acked next cycle");
   stray_ack_a: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
      else $error("ack without request");
   upper_zero_a: assert property (WB_DAT_O[31:8] == 24'h0)
      else $error("upper read bits not zero");
   idle_data_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
      else $error("read data outside ack");
   irq_clear_a: assert property ($fell(IRQ) |->
      $past(WB_ACK_O && WB_WE_I)) else $error("irq fell without write");
   ce_hold_a: assert property (!CE |=> $stable(IRQ) && $stable(WB_ACK_O))
      else $error("state moved with enable low");
   reset_quiet_a: assert property ($fell(RST) |-> !IRQ && !WB_ACK_O)
      else $error("outputs active after reset");
endmodule : uhf_irq_flags_sva
bind uhf_irq_flags uhf_irq_flags_sva chk (.CLK(CLK), .RST(RST), .CE(CE),
   .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
   .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .IRQ(IRQ));

// ===== test/uhf_peer_model.sv
// Attached peripheral model driving the host port line pins
`timescale 1ns/10ps
module uhf_peer_model (
   // Line state chosen by the bench
   input  uhf_pkg::uhf_line_t line,
   // Speed of the attached peripheral
   input  wire logic          low_speed,
   // Line pins
   output logic               dp,
   output logic               dm
);
   wire j_ln = (line == uhf_pkg::UHF_J);
   wire k_ln = (line == uhf_pkg::UHF_K);
   // Full speed: J on D+, K on D-; low speed swaps them; SE0 both low
   assign dp = low_speed ? k_ln : j_ln;
   assign dm = low_speed ? j_ln : k_ln;
endmodule : uhf_peer_model
